// ---- design/can_receive_buffer_store.sv ----
// Overview of operation
// RULE1 - full flag at bit 7, set on store
// RULE2 - software clears full flag after reading
// RULE3 - two-bit mode selects which messages accepted
// RULE4 - bit 3 shows stored remote request
// RULE5 - dual enable spills slot 0 overflow
// RULE6 - bit 1 mirrors dual enable
// RULE7 - slot 0 bit 0 names hit filter
// RULE8 - slot 1 three-bit hit index, 6-7 reserved
// RULE9 - hit index 0/1 only via spill
// RULE10 - identifier bytes follow fixed bit layout
// RULE11 - low byte bit 3 marks extended frame
// RULE12 - bit 4 substitute remote, zero when extended
// RULE13 - length code 0-8 valid, above invalid
// RULE14 - length byte bit 6 remote, 5:4 zero
// RULE15 - eight payload bytes per slot, in order
// RULE16 - fault counter above 127 means passive
// RULE17 - fault counter never causes bus-off
// RULE18 - software loads filters in identifier layout
// RULE19 - filter bit 3 selects frame type
// RULE20 - unimplemented bits read zero
// RULE21 - full and mode bits independent per slot
// RULE22 - slot 1 overrun flag on full arrival
// RULE23 - store only into free slot on match
// RULE24 - slot 0 first; filters 0-1 vs 2-5
`timescale 1ns/1ps
module can_receive_buffer_store
  import can_rx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic frame_valid,
  input wire rx_frame_s frame,
  input wire logic [28:0] slot0_mask_bits,
  input wire logic [28:0] slot1_mask_bits,
  input wire logic rec_step_small,
  input wire logic rec_step_large,
  input wire logic rec_good_frame,
  output logic error_passive,
  output logic [NUM_SLOTS-1:0] slot_occupied_flag,
  output logic slot1_overrun_flag
);

  // ==========================================================
  // helpers
  function automatic reg_sel_s decode(input logic [ADDR_W-1:0] a);
    reg_sel_s s;
    s.kind = SEL_NONE;
    s.slot = a[6];
    s.idx = a[5:2];
    s.filt = a[6:4];
    if (a == OFS_SLOT0_CTRL) begin
      s.kind = SEL_CTRL0;
    end else if (a == OFS_SLOT1_CTRL) begin
      s.kind = SEL_CTRL1;
    end else if (a == OFS_FAULT_CNT) begin
      s.kind = SEL_FAULT;
    end else if (a == OFS_ERR_FLAGS) begin
      s.kind = SEL_ERRFLAGS;
    end else if (a[11:7] == SLOT_REGION && a[1:0] == 2'h0 && a[5:2] < SLOT_IDX_LIMIT) begin
      s.kind = SEL_SLOT;
    end else if (a[11:8] == FILT_REGION && a[7] == 1'b0 && a[1:0] == 2'h0
                 && a[6:4] < FILT_IDX_LIMIT) begin
      s.kind = SEL_FILT;
    end
    return s;
  endfunction

  function automatic logic mode_ok(input logic [1:0] m, input logic ext, input logic err);
    logic ok;
    ok = 1'b0;
    unique case (acceptance_mode_e'(m))
      MODE_ANY: ok = 1'b1;
      MODE_EXT_ONLY: ok = !err && ext;
      MODE_STD_ONLY: ok = !err && !ext;
      MODE_ALL_VALID: ok = !err;
    endcase
    return ok;
  endfunction

  function automatic logic [7:0] slot_wmask(input logic [3:0] idx);
    logic [7:0] m;
    m = BYTE_ALL;
    if (idx == SLOT_IDX_BASE_LO) begin
      m = SIDL_SLOT_MASK;
    end else if (idx == SLOT_IDX_LEN) begin
      m = LEN_MASK;
    end
    return m;
  endfunction

  // ==========================================================
  // state
  logic [7:0] slot_reg_ff [NUM_SLOTS][SLOT_WORDS];
  logic [7:0] filt_reg_ff [NUM_FILTERS][FILT_WORDS];
  logic [NUM_SLOTS-1:0] full_ff;
  logic [1:0] mode_ff [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] rtr_ro_ff;
  logic dben_ff;
  logic hit0_ff;
  logic [2:0] hit1_ff;
  logic ovf0_ff;
  logic ovf1_ff;
  logic [7:0] rec_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ==========================================================
  // acceptance
  logic [28:0] filt_id [NUM_FILTERS];
  logic [NUM_FILTERS-1:0] filt_ext;
  logic [NUM_FILTERS-1:0] filt_hit;

  genvar gf;
  generate
    for (gf = 0; gf < NUM_FILTERS; gf++) begin : g_filt
      logic [28:0] diff;
      assign filt_id[gf] = {filt_reg_ff[gf][0], filt_reg_ff[gf][1][7:5],
                            filt_reg_ff[gf][1][1:0], filt_reg_ff[gf][2], filt_reg_ff[gf][3]};
      assign filt_ext[gf] = filt_reg_ff[gf][1][SIDL_EXT_BIT];
      assign diff = (frame.ident ^ filt_id[gf]) & (gf < 2 ? slot0_mask_bits : slot1_mask_bits);
      // frame type must match filter select; standard compares 11 bits only
      assign filt_hit[gf] = (filt_ext[gf] == frame.ext) &&                     // [RULE19]
                            ((frame.ext ? diff : diff & STD_ID_MASK) == 29'h0);
    end
  endgenerate

  logic hit0_any;
  logic hit0_idx;
  logic hit1_any;
  logic [2:0] hit1_idx;
  logic ok0;
  logic ok1;
  logic spill;
  logic want1;
  logic [2:0] store1_idx;
  logic [NUM_SLOTS-1:0] take;
  logic ovf0_set;
  logic ovf1_set;

  always_comb begin
    hit1_idx = 3'h2;
    for (int f = NUM_FILTERS - 1; f >= 2; f--) begin
      if (filt_hit[f]) begin
        hit1_idx = 3'(f);
      end
    end
  end

  assign hit0_any = filt_hit[0] | filt_hit[1];                                 // [RULE24]
  assign hit0_idx = !filt_hit[0];
  assign hit1_any = |filt_hit[NUM_FILTERS-1:2];
  assign ok0 = mode_ok(mode_ff[0], frame.ext, frame.errored);                  // [RULE3]
  assign ok1 = mode_ok(mode_ff[1], frame.ext, frame.errored);
  assign spill = frame_valid && hit0_any && ok0 && full_ff[0] && dben_ff;      // [RULE5]
  assign want1 = ok1 && (spill || (frame_valid && !(hit0_any && ok0) && hit1_any));
  assign store1_idx = spill ? {2'b00, hit0_idx} : hit1_idx;                    // [RULE9]
  assign take[0] = frame_valid && hit0_any && ok0 && !full_ff[0];              // [RULE23]
  assign take[1] = want1 && !full_ff[1];
  assign ovf0_set = frame_valid && hit0_any && ok0 && full_ff[0] && !dben_ff;
  assign ovf1_set = want1 && full_ff[1];                                       // [RULE22]

  // ==========================================================
  // captured image of the frame
  logic [7:0] cap_byte [SLOT_WORDS];

  always_comb begin
    cap_byte[SLOT_IDX_BASE_HI] = frame.ident[28:21];                           // [RULE10]
    cap_byte[SLOT_IDX_BASE_LO] = {frame.ident[20:18], !frame.ext && frame.rtr, // [RULE12]
                                  frame.ext, 1'b0, frame.ident[17:16]};        // [RULE11]
    cap_byte[SLOT_IDX_EXT_HI] = frame.ident[15:8];
    cap_byte[SLOT_IDX_EXT_LO] = frame.ident[7:0];
    cap_byte[SLOT_IDX_LEN] = {1'b0, frame.rtr, 2'b00, frame.length_code}; // [RULE13] [RULE14]
    for (int b = 0; b < DATA_BYTES; b++) begin
      cap_byte[int'(SLOT_IDX_DATA0) + b] = frame.payload[8*b +: 8];            // [RULE15]
    end
  end

  // ==========================================================
  // bus write side
  reg_sel_s wr_sel;
  logic wr_go;
  logic wr_ok;
  logic [NUM_SLOTS-1:0] wr_ctrl;

  assign wr_sel = decode(aw_addr_ff);
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ok = wr_go && w_strb_ff;
  assign wr_ctrl[0] = wr_ok && wr_sel.kind == SEL_CTRL0;
  assign wr_ctrl[1] = wr_ok && wr_sel.kind == SEL_CTRL1;
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (awvalid && awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= wdata[7:0];
      w_strb_ff <= wstrb[0];
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_sel.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // slot storage and control
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          for (int w = 0; w < SLOT_WORDS; w++) begin
            slot_reg_ff[gs][w] <= '0;
          end
        end else if (take[gs]) begin
          for (int w = 0; w < SLOT_WORDS; w++) begin
            slot_reg_ff[gs][w] <= cap_byte[w];
          end
        end else if (wr_ok && wr_sel.kind == SEL_SLOT && wr_sel.slot == 1'(gs)) begin
          slot_reg_ff[gs][wr_sel.idx] <= w_data_ff & slot_wmask(wr_sel.idx);   // [RULE20]
        end
      end

      // store sets, software write of zero clears; store wins
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          full_ff[gs] <= 1'b0;
        end else if (take[gs]) begin
          full_ff[gs] <= 1'b1;                                                 // [RULE1]
        end else if (wr_ctrl[gs] && !w_data_ff[CTRL_FULL_BIT]) begin
          full_ff[gs] <= 1'b0;                                                 // [RULE2]
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          mode_ff[gs] <= MODE_ALL_VALID;
        end else if (wr_ctrl[gs]) begin
          mode_ff[gs] <= w_data_ff[CTRL_MODE_HI:CTRL_MODE_LO];                // [RULE21]
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          rtr_ro_ff[gs] <= 1'b0;
        end else if (take[gs]) begin
          rtr_ro_ff[gs] <= frame.rtr;                                          // [RULE4]
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dben_ff <= 1'b0;
    end else if (wr_ctrl[0]) begin
      dben_ff <= w_data_ff[CTRL_DBEN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hit0_ff <= 1'b0;
      hit1_ff <= '0;
    end else begin
      if (take[0]) begin
        hit0_ff <= hit0_idx;                                                   // [RULE7]
      end
      if (take[1]) begin
        hit1_ff <= store1_idx;                                                 // [RULE8]
      end
    end
  end

  // ==========================================================
  // filters and error flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int f = 0; f < NUM_FILTERS; f++) begin
        for (int w = 0; w < FILT_WORDS; w++) begin
          filt_reg_ff[f][w] <= '0;
        end
      end
    end else if (wr_ok && wr_sel.kind == SEL_FILT) begin
      filt_reg_ff[wr_sel.filt][wr_sel.idx[1:0]] <=
        (wr_sel.idx[1:0] == FILT_IDX_BASE_LO) ? (w_data_ff & SIDL_FILT_MASK) : w_data_ff;
    end
  end

  // overflow flags: set wins over a software write of zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf0_ff <= 1'b0;
      ovf1_ff <= 1'b0;
    end else begin
      if (ovf0_set) begin
        ovf0_ff <= 1'b1;
      end else if (wr_ok && wr_sel.kind == SEL_ERRFLAGS && !w_data_ff[ERR_OVF0_BIT]) begin
        ovf0_ff <= 1'b0;
      end
      if (ovf1_set) begin
        ovf1_ff <= 1'b1;                                                       // [RULE22]
      end else if (wr_ok && wr_sel.kind == SEL_ERRFLAGS && !w_data_ff[ERR_OVF1_BIT]) begin
        ovf1_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // receive fault counter
  logic [8:0] rec_sum;

  assign rec_sum = {1'b0, rec_ff} + (rec_step_large ? REC_STEP_LARGE : REC_STEP_SMALL);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rec_ff <= '0;
    end else if (rec_step_large || rec_step_small) begin
      rec_ff <= rec_sum[8] ? REC_MAX : rec_sum[7:0];
    end else if (rec_good_frame) begin
      if (rec_ff > REC_PASSIVE_LIMIT) begin
        rec_ff <= REC_RELOAD;
      end else if (rec_ff != 8'h00) begin
        rec_ff <= rec_ff - 8'h01;
      end
    end
  end

  // passive only; there is deliberately no bus-off path from this count
  assign error_passive = rec_ff > REC_PASSIVE_LIMIT;                           // [RULE16] [RULE17]

  // ==========================================================
  // bus read side
  logic [7:0] ctrl_byte [NUM_SLOTS];
  logic [7:0] rd_byte;
  reg_sel_s rd_sel;

  always_comb begin
    ctrl_byte[0] = {full_ff[0], mode_ff[0], 1'b0, rtr_ro_ff[0], dben_ff,
                    dben_ff, hit0_ff};                                          // [RULE6]
    ctrl_byte[1] = {full_ff[1], mode_ff[1], 1'b0, rtr_ro_ff[1], hit1_ff};      // [RULE20]
  end

  assign rd_sel = decode(araddr);

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_sel.kind)
      SEL_CTRL0: rd_byte = ctrl_byte[0];
      SEL_CTRL1: rd_byte = ctrl_byte[1];
      SEL_FAULT: rd_byte = rec_ff;
      SEL_ERRFLAGS: rd_byte = {ovf0_ff, ovf1_ff, 2'b00, error_passive, 3'b000};
      SEL_SLOT: rd_byte = slot_reg_ff[rd_sel.slot][rd_sel.idx];
      SEL_FILT: rd_byte = filt_reg_ff[rd_sel.filt][rd_sel.idx[1:0]];
      SEL_NONE: rd_byte = 8'h00;
    endcase
  end

  assign arready = !rvalid_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, rd_byte};
      rresp_ff <= (rd_sel.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign slot_occupied_flag = full_ff;
  assign slot1_overrun_flag = ovf1_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  full_set_a: assert property (take[0] |=> full_ff[0] && slot_occupied_flag[0]) // [RULE1]
    else $error("slot 0 not marked full after store");
  mode_std_a: assert property (frame_valid && frame.ext                         // [RULE3]
      && mode_ff[1] == MODE_STD_ONLY |=> $stable(full_ff[1]) || !full_ff[1])
    else $error("standard-only slot took extended frame");
  rtr_copy_a: assert property (take[1] |=> rtr_ro_ff[1] == $past(frame.rtr))   // [RULE4]
    else $error("remote copy wrong");
  spill_go_a: assert property (spill && ok1 && !full_ff[1]                      // [RULE5]
      |=> full_ff[1] && hit1_ff == {2'b00, $past(hit0_idx)})
    else $error("overflow not spilled into slot 1");
  branch_copy_a: assert property (arvalid && arready && rd_sel.kind == SEL_CTRL0 // [RULE6]
      |=> rdata[CTRL_BRANCH_BIT] == rdata[CTRL_DBEN_BIT] && rdata[4] == 1'b0)
    else $error("branch offset copy mismatch");
  hit_zero_a: assert property (take[0] |=> hit0_ff == !$past(filt_hit[0]))     // [RULE7]
    else $error("slot 0 filter hit wrong");
  hit_range_a: assert property (hit1_ff <= HIT_LAST_VALID)                      // [RULE8]
    else $error("reserved hit code");
  low_hit_a: assert property (take[1] && store1_idx < 3'h2 |-> dben_ff)         // [RULE9]
    else $error("filter 0/1 hit in slot 1 without dual enable");
  ext_flag_a: assert property (take[0] |=>                                      // [RULE11]
      slot_reg_ff[0][SLOT_IDX_BASE_LO][SIDL_EXT_BIT] == $past(frame.ext)
      && slot_reg_ff[0][SLOT_IDX_BASE_LO][SIDL_SRR_BIT] == (!$past(frame.ext) && rtr_ro_ff[0]))
    else $error("identifier low byte flags wrong");
  rec_sat_a: assert property (rec_step_large && rec_ff == REC_MAX               // [RULE16]
      |=> rec_ff == REC_MAX && error_passive)
    else $error("fault count wrapped");
  ovf_set_a: assert property (ovf1_set |=> slot1_overrun_flag)                  // [RULE22]
    else $error("overrun flag not set");
  no_over_a: assert property (full_ff[0] && !(wr_ok && wr_sel.kind == SEL_SLOT) // [RULE23]
      |=> $stable(slot_reg_ff[0][SLOT_IDX_LEN]))
    else $error("store into full slot");

endmodule

// ---- design/can_rx_pkg.sv ----
package can_rx_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_SLOTS = 2;
  localparam int NUM_FILTERS = 6;
  localparam int DATA_BYTES = 8;
  localparam int SLOT_WORDS = 13;
  localparam int FILT_WORDS = 4;
  localparam int ADDR_W = 12;

  // ==========================================================
  // register map, byte addresses
  localparam logic [11:0] OFS_SLOT0_CTRL = 12'h000;
  localparam logic [11:0] OFS_SLOT1_CTRL = 12'h004;
  localparam logic [11:0] OFS_FAULT_CNT = 12'h008;
  localparam logic [11:0] OFS_ERR_FLAGS = 12'h00C;
  // slot n word w at 0x080 + n*0x040 + w*4
  localparam logic [4:0] SLOT_REGION = 5'h01;
  // filter f word w at 0x100 + f*0x010 + w*4
  localparam logic [3:0] FILT_REGION = 4'h1;
  localparam logic [3:0] SLOT_IDX_BASE_HI = 4'h0;
  localparam logic [3:0] SLOT_IDX_BASE_LO = 4'h1;
  localparam logic [3:0] SLOT_IDX_EXT_HI = 4'h2;
  localparam logic [3:0] SLOT_IDX_EXT_LO = 4'h3;
  localparam logic [3:0] SLOT_IDX_LEN = 4'h4;
  localparam logic [3:0] SLOT_IDX_DATA0 = 4'h5;
  localparam logic [3:0] SLOT_IDX_LIMIT = 4'hD;
  localparam logic [2:0] FILT_IDX_LIMIT = 3'h6;
  localparam logic [1:0] FILT_IDX_BASE_LO = 2'h1;

  // ==========================================================
  // field positions and masks
  localparam int CTRL_FULL_BIT = 7;
  localparam int CTRL_MODE_HI = 6;
  localparam int CTRL_MODE_LO = 5;
  localparam int CTRL_RTR_BIT = 3;
  localparam int CTRL_DBEN_BIT = 2;
  localparam int CTRL_BRANCH_BIT = 1;
  localparam int CTRL_HIT0_BIT = 0;
  localparam int SIDL_SRR_BIT = 4;
  localparam int SIDL_EXT_BIT = 3;
  localparam int LEN_RTR_BIT = 6;
  localparam int ERR_OVF0_BIT = 7;
  localparam int ERR_OVF1_BIT = 6;
  localparam int ERR_PASSIVE_BIT = 3;
  localparam logic [7:0] SIDL_SLOT_MASK = 8'hFB;
  localparam logic [7:0] SIDL_FILT_MASK = 8'hEB;
  localparam logic [7:0] LEN_MASK = 8'h4F;
  localparam logic [7:0] BYTE_ALL = 8'hFF;
  localparam logic [28:0] STD_ID_MASK = 29'h1FFC0000;
  localparam logic [2:0] HIT_LAST_VALID = 3'h5;

  // ==========================================================
  // receive fault counter
  localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
  localparam logic [7:0] REC_RELOAD = 8'h77;
  localparam logic [7:0] REC_MAX = 8'hFF;
  localparam logic [8:0] REC_STEP_SMALL = 9'h001;
  localparam logic [8:0] REC_STEP_LARGE = 9'h008;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_ALL_VALID = 2'h0,
    MODE_STD_ONLY = 2'h1,
    MODE_EXT_ONLY = 2'h2,
    MODE_ANY = 2'h3
  } acceptance_mode_e;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTRL0, SEL_CTRL1, SEL_FAULT, SEL_ERRFLAGS, SEL_SLOT, SEL_FILT
  } reg_kind_e;

  typedef struct packed {
    reg_kind_e kind;
    logic slot;
    logic [3:0] idx;
    logic [2:0] filt;
  } reg_sel_s;

  // standard identifiers sit in ident[28:18]
  typedef struct packed {
    logic [28:0] ident;
    logic ext;
    logic rtr;
    logic [3:0] length_code;
    logic [63:0] payload;
    logic errored;
  } rx_frame_s;

endpackage

// ---- testbench/can_frame_source.sv ----
`timescale 1ns/1ps
module can_frame_source
  import can_rx_pkg::*;
(
  input wire logic sys_clk,
  output logic frame_valid,
  output rx_frame_s frame
);
  initial begin
    frame_valid = 1'h0;
    frame = '1;
  end
  // ==========================================================
  // one-cycle pulse per finished frame, bus scrambled between frames
  task automatic send(input rx_frame_s f);
    frame <= f;
    frame_valid <= 1'h1;
    @(posedge sys_clk);
    frame_valid <= 1'h0;
    frame <= ~f;
    @(posedge sys_clk);
  endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import can_rx_pkg::*;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, error_passive, slot1_overrun_flag;
  logic [1:0] bresp, rresp, slot_occupied_flag, r;
  logic [31:0] rdata, v;
  logic frame_valid, st;
  rx_frame_s frame, fs, fx;
  logic [28:0] slot0_mask_bits = STD_ID_MASK;
  logic [28:0] slot1_mask_bits = 29'h1FFFFFFF;
  logic rec_step_small = 1'h0, rec_step_large = 1'h0, rec_good_frame = 1'h0;
  int err_total = 0;
  int samples_checked = 0;

  can_receive_buffer_store u_can_receive_buffer_store (
    .sys_clk(sys_clk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .frame_valid(frame_valid), .frame(frame),
    .slot0_mask_bits(slot0_mask_bits), .slot1_mask_bits(slot1_mask_bits),
    .rec_step_small(rec_step_small), .rec_step_large(rec_step_large),
    .rec_good_frame(rec_good_frame), .error_passive(error_passive),
    .slot_occupied_flag(slot_occupied_flag), .slot1_overrun_flag(slot1_overrun_flag)
  );
  can_frame_source src (.sys_clk(sys_clk), .frame_valid(frame_valid), .frame(frame));

  initial forever #2 sys_clk = ~sys_clk;

  // ==========================================================
  // bus access tasks
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic ad, dd, ar_s, w_s, b;
    ad = 1'h0;
    dd = 1'h0;
    b = 1'h0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && dd)) begin
      #1;
      ar_s = awready;
      w_s = wready;
      @(posedge sys_clk);
      if (!ad && ar_s) begin
        awvalid <= 1'h0;
        ad = 1'h1;
      end
      if (!dd && w_s) begin
        wvalid <= 1'h0;
        dd = 1'h1;
      end
    end
    while (!b) begin
      #1;
      b = bvalid;
      r = bresp;
      @(posedge sys_clk);
    end
  endtask
  task rd(input logic [11:0] a);
    logic ar_s, got;
    ar_s = 1'h0;
    got = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!ar_s) begin
      #1;
      ar_s = arready;
      @(posedge sys_clk);
    end
    arvalid <= 1'h0;
    while (!got) begin
      #1;
      got = rvalid;
      v = rdata;
      r = rresp;
      @(posedge sys_clk);
    end
  endtask
  task rc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), v, {24'h0, e});
  endtask
  task summarize;
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize;
  end

  // ==========================================================
  // test sequence
  initial begin
    fs = '0;
    fs.ident = 29'h048C0000;
    fs.rtr = 1'h1;
    fs.length_code = 4'h8;
    fs.payload = 64'h8877665544332211;
    fx = '0;
    fx.ident = 29'h1ABCDE12;
    fx.ext = 1'h1;
    fx.length_code = 4'h2;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    rc(OFS_SLOT0_CTRL, 8'h00);
    rc(OFS_FAULT_CNT, 8'h00);
    rd(12'hFFC);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", v, 32'h0);
    wr(12'hFFC, 8'h00);
    chk("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(12'h100, 8'h24);
    wr(12'h104, 8'h74);
    rc(12'h104, 8'h60);
    wr(12'h120, 8'hD5);
    wr(12'h124, 8'hE8);
    wr(12'h128, 8'hDE);
    wr(12'h12C, 8'h12);
    rc(12'h124, 8'hE8);
    src.send(fs);
    chk("occupied", {30'h0, slot_occupied_flag}, 32'h1);
    rc(OFS_SLOT0_CTRL, 8'h88);
    rc(12'h080, 8'h24);
    rc(12'h084, 8'h70);
    rc(12'h090, 8'h48);
    for (int b = 0; b < 8; b++)
      rc(12'h094 + 12'(4 * b), 8'(8'h11 * (b + 1)));
    wr(OFS_SLOT0_CTRL, 8'h84);
    rc(OFS_SLOT0_CTRL, 8'h8E);
    fs.rtr = 1'h0;
    src.send(fs);
    rc(OFS_SLOT1_CTRL, 8'h80);
    rc(12'h090, 8'h48);
    src.send(fs);
    chk("overrun", {31'h0, slot1_overrun_flag}, 32'h1);
    rc(OFS_ERR_FLAGS, 8'h40);
    wr(OFS_ERR_FLAGS, 8'h00);
    wr(OFS_SLOT1_CTRL, 8'h00);
    wr(OFS_SLOT0_CTRL, 8'h80);
    src.send(fs);
    rc(OFS_SLOT1_CTRL, 8'h00);
    rc(OFS_ERR_FLAGS, 8'h80);
    wr(OFS_SLOT0_CTRL, 8'h00);
    chk("occupied", {30'h0, slot_occupied_flag}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      fx.errored = i[2];
      wr(OFS_SLOT1_CTRL, {1'h0, i[1:0], 5'h00});
      src.send(fx);
      st = i[2] ? (i[1:0] == 2'h3) : (i[1:0] != 2'h1);
      rc(OFS_SLOT1_CTRL, {st, i[1:0], 2'h0, 3'h2});
    end
    rc(OFS_SLOT0_CTRL, 8'h08);
    rc(12'h0C0, 8'hD5);
    rc(12'h0C4, 8'hE8);
    rc(12'h0CC, 8'h12);
    rec_step_large <= 1'h1;
    repeat (16) @(posedge sys_clk);
    rec_step_large <= 1'h0;
    rec_step_small <= 1'h1;
    @(posedge sys_clk);
    rec_step_small <= 1'h0;
    rc(OFS_FAULT_CNT, 8'h81);
    chk("passive", {31'h0, error_passive}, 32'h1);
    rc(OFS_ERR_FLAGS, 8'h88);
    rec_good_frame <= 1'h1;
    @(posedge sys_clk);
    rec_good_frame <= 1'h0;
    rc(OFS_FAULT_CNT, 8'h77);
    chk("passive", {31'h0, error_passive}, 32'h0);
    rec_step_large <= 1'h1;
    repeat (24) @(posedge sys_clk);
    rec_step_large <= 1'h0;
    rc(OFS_FAULT_CNT, 8'hFF);
    summarize;
  end
endmodule
